// >>> pgcfg_host.sv
/*
 Host model for the register port: one write or one read at a time.
 Assumes the slice shares sys_clk and answers a read one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module pgcfg_host (
	input wire logic sys_clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// Idle port at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One-cycle write; idle bus shows inverted values so stale data never matches
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// One-cycle read, then a bounded wait for the answer
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (reg_rvalid === 1'b1) begin
				d = reg_rdata;
				ok = 1'b1;
			end else begin
				@(posedge sys_clk);
			end
		end
	endtask
endmodule // pgcfg_host
`default_nettype wire

// >>> pgcfg_pkg.sv
/*
 Package for the power-good and miscellaneous configuration slice:
 register offsets, field positions, reset values and encodings.
 Assumes an 8-bit register port with 8-bit offsets from the serial host logic.
*/
package pgcfg_pkg;
	localparam logic [7:0] OFS_PG_SEL_FOUR = 8'h7b;
	localparam logic [7:0] OFS_SYNC_FREQ = 8'h7c;
	localparam logic [7:0] OFS_GEN_CFG_ONE = 8'h7d;
	localparam logic [7:0] OFS_DRV_CTRL = 8'h80;
	localparam logic [7:0] OFS_MISC_CTRL = 8'h81;
	localparam logic [7:0] RST_PG_SEL_FOUR = 8'h00;
	localparam logic [7:0] RST_SYNC_FREQ = 8'h00;
	localparam logic [7:0] RST_GEN_CFG_ONE = 8'hc0;
	localparam logic [7:0] RST_DRV_CTRL = 8'h00;
	localparam logic [7:0] RST_MISC_CTRL = 8'h00;
	// Source select register fields
	localparam int B_PG_WINDOW = 7;
	localparam int B_PG_POL = 6;
	localparam int B_PG_SOC_RST = 5;
	localparam int B_PG_RST_OUT = 4;
	localparam int B_PG_TWARN = 3;
	localparam int B_PG_MON_TWO = 2;
	localparam int B_PG_MON_ONE = 1;
	localparam int B_PG_ANALOG = 0;
	// General configuration fields
	localparam int B_SLEEP_TWO_MASK = 7;
	localparam int B_SLEEP_ONE_MASK = 6;
	localparam int B_CURRENT_LIMIT_EVENT_TRIG = 5;
	localparam int B_I2C_TWO_HS = 4;
	localparam int B_I2C_ONE_HS = 3;
	localparam int B_TSD_ORD = 1;
	localparam int B_TWARN_LVL = 0;
	localparam int B_DRV_CTRL = 0;
	localparam logic [7:0] SYNC_FREQ_MASK = 8'h03;
	localparam logic [7:0] DRV_CTRL_MASK = 8'h01;
	// Regulator power-good select encodings
	localparam logic [1:0] PG_REG_MASKED = 2'h0;
	localparam logic [1:0] PG_REG_VOLT = 2'h1;
	// Frequency in kHz for each sync frequency code
	localparam logic [13:0] SYNC_KHZ_0 = 14'h44c;
	localparam logic [13:0] SYNC_KHZ_1 = 14'h898;
	localparam logic [13:0] SYNC_KHZ_2 = 14'h1130;
	localparam logic [13:0] SYNC_KHZ_3 = 14'h2260;
	// Thermal thresholds in degrees C
	localparam logic [7:0] TSD_ORD_LO = 8'h8c;
	localparam logic [7:0] TSD_ORD_HI = 8'h91;
	localparam logic [7:0] TWARN_LO = 8'h82;
	localparam logic [7:0] TWARN_HI = 8'h8c;
endpackage

// >>> pgcfg_regulator.sv
/*
 Power-good qualifier for one buck output with a two-bit select.
 Assumes voltage and current-limit flags are synchronous, high meaning ok.
*/
`timescale 1ns/10ps
`default_nettype none
module pgcfg_regulator (
	input wire logic [1:0] sel,
	input wire logic window_mode,
	input wire logic uv_ok,
	input wire logic ov_ok,
	input wire logic current_limit_event_ok,
	output logic ok
);
	logic volt_ok;
	// Voltage check, then current limit for codes above voltage-only
	assign volt_ok = uv_ok && (ov_ok || !window_mode);
	assign ok = (sel == pgcfg_pkg::PG_REG_MASKED) ||
		(volt_ok && ((sel == pgcfg_pkg::PG_REG_VOLT) || current_limit_event_ok));
endmodule // pgcfg_regulator
`default_nettype wire

// >>> pgcfg_source.sv
/*
 One power-good source: gates its fault with a select and a window mode.
 Assumes monitor results are synchronous level flags, high meaning ok.
*/
`timescale 1ns/10ps
`default_nettype none
module pgcfg_source (
	input wire logic sel,
	input wire logic window_mode,
	input wire logic uv_ok,
	input wire logic ov_ok,
	output logic ok
);
	// Masked source reads as valid; overvoltage only counts in window mode
	assign ok = !sel || (uv_ok && (ov_ok || !window_mode));
endmodule // pgcfg_source
`default_nettype wire

// >>> pgcfg_top.sv
/*
 Power-good and miscellaneous configuration register slice.
 Assumes a synchronous 8-bit register port from the serial host logic
 and a one-cycle load strobe carrying non-volatile defaults.
*/
// Summary of operation
// - Window bit 0 checks undervoltage only; 1 checks under and overvoltage.
// - Polarity 0 drives power-good high when valid; 1 drives it low.
// - SoC reset select 1 lets a low SoC reset pin force power-good invalid.
// - Reset-out select 1 lets a low reset pin force power-good invalid.
// - Thermal warning select 1 lets an active warning pull power-good invalid.
// - Each monitor and analog supply has a select; 0 masks its result.
// - Source select, sync and general config defaults come from the non-volatile memory load.
// - Two-bit sync field encodes 1.1, 2.2, 4.4 or 8.8 MHz.
// - Second sleep mask 1 hides second sleep inputs from the sequencer.
// - First sleep mask 1 hides first sleep inputs from the sequencer.
// - Current-limit trigger bit 1 passes regulator current-limit events to sequencer.
// - Each I2C speed bit 1 forces Hs-mode; 0 allows controller-code entry.
// - Ordered shutdown threshold is 140C at 0 and 145C at 1.
// - Thermal warning threshold is 130C at 0 and 140C at 1.
// - Drive pin follows control bit only while force-low is 0.
// - Buck select 00 masked, 01 voltage, 10 or 11 voltage and current limit.
`timescale 1ns/10ps
`default_nettype none
module pgcfg_top #(
	parameter int NUM_BUCK = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic nvm_load,
	input wire logic [7:0] nvm_pg_sel_four,
	input wire logic [7:0] nvm_sync_freq,
	input wire logic [7:0] nvm_gen_cfg_one,
	input wire logic [2*NUM_BUCK-1:0] pg_regulator_source_sel,
	input wire logic [NUM_BUCK-1:0] buck_uv_ok,
	input wire logic [NUM_BUCK-1:0] buck_ov_ok,
	input wire logic [NUM_BUCK-1:0] buck_current_limit_event_ok,
	input wire logic mon_one_uv_ok,
	input wire logic mon_one_ov_ok,
	input wire logic mon_two_uv_ok,
	input wire logic mon_two_ov_ok,
	input wire logic analog_uv_ok,
	input wire logic analog_ov_ok,
	input wire logic thermal_warn,
	input wire logic soc_reset_output_pin,
	input wire logic general_reset_output_pin,
	input wire logic drive_output_force_low_bit,
	input wire logic sleep_one_pins,
	input wire logic sleep_one_register_twin,
	input wire logic sleep_two_pins,
	input wire logic sleep_two_register_twin,
	input wire logic [NUM_BUCK-1:0] current_limit_event,
	output logic power_good_output,
	output logic drive_output_pin,
	output logic [1:0] sync_input_frequency_field,
	output logic [13:0] sync_expected_khz,
	output logic sleep_one_to_seq,
	output logic sleep_one_active,
	output logic sleep_two_to_seq,
	output logic sleep_two_active,
	output logic [NUM_BUCK-1:0] current_limit_trigger,
	output logic first_i2c_high_speed_force,
	output logic second_i2c_high_speed_force,
	output logic [7:0] ordered_shutdown_threshold_c,
	output logic [7:0] thermal_warning_threshold_c,
	output logic [7:0] misc_control
);
	typedef struct packed {
		logic [7:0] pg_sel_four;
		logic [7:0] sync_freq;
		logic [7:0] gen_cfg_one;
		logic [7:0] drv_ctrl;
		logic [7:0] misc_ctrl;
		logic [7:0] rdata;
		logic rvalid;
		logic pg_out;
		logic drv_pin;
		logic [13:0] sync_khz;
		logic sl1_en;
		logic sl1_act;
		logic sl2_en;
		logic sl2_act;
		logic [NUM_BUCK-1:0] current_limit_event_trig;
		logic [7:0] tsd_c;
		logic [7:0] twarn_c;
	} pgcfg_state_s;

	pgcfg_state_s st;
	pgcfg_state_s next_st;
	logic [NUM_BUCK-1:0] buck_ok;
	logic mon_one_ok;
	logic mon_two_ok;
	logic analog_ok;
	logic all_valid;
	logic window_mode;

	assign window_mode = st.pg_sel_four[pgcfg_pkg::B_PG_WINDOW];

	// Per-regulator qualifiers
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BUCK; gi++) begin : g_buck
			pgcfg_regulator u_reg (
				.sel(pg_regulator_source_sel[2*gi +: 2]),
				.window_mode(window_mode),
				.uv_ok(buck_uv_ok[gi]),
				.ov_ok(buck_ov_ok[gi]),
				.current_limit_event_ok(buck_current_limit_event_ok[gi]),
				.ok(buck_ok[gi])
			);
			// Masked buck always passes; codes 1x also need the current limit
			buck_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
				pg_regulator_source_sel[2*gi +: 2] == pgcfg_pkg::PG_REG_MASKED |-> buck_ok[gi])
				else $error("masked buck counted");
			buck_current_limit_event_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
				pg_regulator_source_sel[2*gi+1] && !buck_current_limit_event_ok[gi] |-> !buck_ok[gi])
				else $error("buck current limit ignored");
		end
	endgenerate

	// Voltage monitor and analog supply qualifiers
	pgcfg_source u_mon_one (
		.sel(st.pg_sel_four[pgcfg_pkg::B_PG_MON_ONE]),
		.window_mode(window_mode),
		.uv_ok(mon_one_uv_ok),
		.ov_ok(mon_one_ov_ok),
		.ok(mon_one_ok)
	);
	pgcfg_source u_mon_two (
		.sel(st.pg_sel_four[pgcfg_pkg::B_PG_MON_TWO]),
		.window_mode(window_mode),
		.uv_ok(mon_two_uv_ok),
		.ov_ok(mon_two_ov_ok),
		.ok(mon_two_ok)
	);
	pgcfg_source u_analog (
		.sel(st.pg_sel_four[pgcfg_pkg::B_PG_ANALOG]),
		.window_mode(window_mode),
		.uv_ok(analog_uv_ok),
		.ov_ok(analog_ov_ok),
		.ok(analog_ok)
	);

	// Combine every unmasked source
	assign all_valid = (&buck_ok) && mon_one_ok && mon_two_ok && analog_ok &&
		(!st.pg_sel_four[pgcfg_pkg::B_PG_TWARN] || !thermal_warn) &&
		(!st.pg_sel_four[pgcfg_pkg::B_PG_SOC_RST] || soc_reset_output_pin) &&
		(!st.pg_sel_four[pgcfg_pkg::B_PG_RST_OUT] || general_reset_output_pin);

	// Next state: register access, defaults load and derived outputs
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		if (nvm_load) begin
			next_st.pg_sel_four = nvm_pg_sel_four;
			next_st.sync_freq = nvm_sync_freq & pgcfg_pkg::SYNC_FREQ_MASK;
			next_st.gen_cfg_one = nvm_gen_cfg_one;
		end else if (reg_wr) begin
			if (reg_addr == pgcfg_pkg::OFS_PG_SEL_FOUR) begin
				next_st.pg_sel_four = reg_wdata;
			end else if (reg_addr == pgcfg_pkg::OFS_SYNC_FREQ) begin
				next_st.sync_freq = reg_wdata & pgcfg_pkg::SYNC_FREQ_MASK;
			end else if (reg_addr == pgcfg_pkg::OFS_GEN_CFG_ONE) begin
				next_st.gen_cfg_one = reg_wdata;
			end else if (reg_addr == pgcfg_pkg::OFS_DRV_CTRL) begin
				next_st.drv_ctrl = reg_wdata & pgcfg_pkg::DRV_CTRL_MASK;
			end else if (reg_addr == pgcfg_pkg::OFS_MISC_CTRL) begin
				next_st.misc_ctrl = reg_wdata;
			end
		end
		if (reg_rd) begin
			next_st.rvalid = 1'b1;
			if (reg_addr == pgcfg_pkg::OFS_PG_SEL_FOUR) begin
				next_st.rdata = st.pg_sel_four;
			end else if (reg_addr == pgcfg_pkg::OFS_SYNC_FREQ) begin
				next_st.rdata = st.sync_freq;
			end else if (reg_addr == pgcfg_pkg::OFS_GEN_CFG_ONE) begin
				next_st.rdata = st.gen_cfg_one;
			end else if (reg_addr == pgcfg_pkg::OFS_DRV_CTRL) begin
				next_st.rdata = st.drv_ctrl;
			end else if (reg_addr == pgcfg_pkg::OFS_MISC_CTRL) begin
				next_st.rdata = st.misc_ctrl;
			end else begin
				next_st.rdata = 8'h00;
			end
		end
		// Polarity applied to the combined result
		next_st.pg_out = all_valid ^ st.pg_sel_four[pgcfg_pkg::B_PG_POL];
		next_st.drv_pin = st.drv_ctrl[pgcfg_pkg::B_DRV_CTRL] && !drive_output_force_low_bit;
		case (st.sync_freq[1:0])
			2'h0: next_st.sync_khz = pgcfg_pkg::SYNC_KHZ_0;
			2'h1: next_st.sync_khz = pgcfg_pkg::SYNC_KHZ_1;
			2'h2: next_st.sync_khz = pgcfg_pkg::SYNC_KHZ_2;
			default: next_st.sync_khz = pgcfg_pkg::SYNC_KHZ_3;
		endcase
		next_st.sl1_en = !st.gen_cfg_one[pgcfg_pkg::B_SLEEP_ONE_MASK];
		next_st.sl1_act = !st.gen_cfg_one[pgcfg_pkg::B_SLEEP_ONE_MASK] &&
			(!sleep_one_pins || !sleep_one_register_twin);
		next_st.sl2_en = !st.gen_cfg_one[pgcfg_pkg::B_SLEEP_TWO_MASK];
		next_st.sl2_act = !st.gen_cfg_one[pgcfg_pkg::B_SLEEP_TWO_MASK] &&
			(!sleep_two_pins || !sleep_two_register_twin);
		next_st.current_limit_event_trig = current_limit_event &
			{NUM_BUCK{st.gen_cfg_one[pgcfg_pkg::B_CURRENT_LIMIT_EVENT_TRIG]}};
		next_st.tsd_c = st.gen_cfg_one[pgcfg_pkg::B_TSD_ORD] ?
			pgcfg_pkg::TSD_ORD_HI : pgcfg_pkg::TSD_ORD_LO;
		next_st.twarn_c = st.gen_cfg_one[pgcfg_pkg::B_TWARN_LVL] ?
			pgcfg_pkg::TWARN_HI : pgcfg_pkg::TWARN_LO;
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.pg_sel_four <= pgcfg_pkg::RST_PG_SEL_FOUR;
			st.sync_freq <= pgcfg_pkg::RST_SYNC_FREQ;
			st.gen_cfg_one <= pgcfg_pkg::RST_GEN_CFG_ONE;
			st.drv_ctrl <= pgcfg_pkg::RST_DRV_CTRL;
			st.misc_ctrl <= pgcfg_pkg::RST_MISC_CTRL;
			st.sync_khz <= pgcfg_pkg::SYNC_KHZ_0;
			st.tsd_c <= pgcfg_pkg::TSD_ORD_LO;
			st.twarn_c <= pgcfg_pkg::TWARN_LO;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign power_good_output = st.pg_out;
	assign drive_output_pin = st.drv_pin;
	assign sync_input_frequency_field = st.sync_freq[1:0];
	assign sync_expected_khz = st.sync_khz;
	assign sleep_one_to_seq = st.sl1_en;
	assign sleep_one_active = st.sl1_act;
	assign sleep_two_to_seq = st.sl2_en;
	assign sleep_two_active = st.sl2_act;
	assign current_limit_trigger = st.current_limit_event_trig;
	assign first_i2c_high_speed_force = st.gen_cfg_one[pgcfg_pkg::B_I2C_ONE_HS];
	assign second_i2c_high_speed_force = st.gen_cfg_one[pgcfg_pkg::B_I2C_TWO_HS];
	assign ordered_shutdown_threshold_c = st.tsd_c;
	assign thermal_warning_threshold_c = st.twarn_c;
	assign misc_control = st.misc_ctrl;

	// Checks
	sequence soc_low_s;
		st.pg_sel_four[pgcfg_pkg::B_PG_SOC_RST] && !soc_reset_output_pin;
	endsequence
	sequence rst_low_s;
		st.pg_sel_four[pgcfg_pkg::B_PG_RST_OUT] && !general_reset_output_pin;
	endsequence
	pol_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_n && all_valid |=> power_good_output == !$past(st.pg_sel_four[pgcfg_pkg::B_PG_POL]))
		else $error("power good polarity wrong");
	soc_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		soc_low_s |=> power_good_output == $past(st.pg_sel_four[pgcfg_pkg::B_PG_POL]))
		else $error("soc reset did not force power good");
	rst_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_low_s |=> power_good_output == $past(st.pg_sel_four[pgcfg_pkg::B_PG_POL]))
		else $error("reset out did not force power good");
	twarn_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st.pg_sel_four[pgcfg_pkg::B_PG_TWARN] && thermal_warn) |-> !all_valid)
		else $error("thermal warning not counted");
	drv_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		drive_output_force_low_bit |=> !drive_output_pin)
		else $error("drive pin not held low");
	nvm_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		nvm_load |=> st.gen_cfg_one == $past(nvm_gen_cfg_one))
		else $error("defaults not loaded");
	current_limit_event_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!st.gen_cfg_one[pgcfg_pkg::B_CURRENT_LIMIT_EVENT_TRIG] ##1
		!$past(st.gen_cfg_one[pgcfg_pkg::B_CURRENT_LIMIT_EVENT_TRIG]) |-> current_limit_trigger == '0)
		else $error("current limit passed while disabled");
	sleep_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.gen_cfg_one[pgcfg_pkg::B_SLEEP_ONE_MASK] |=> !sleep_one_active)
		else $error("masked sleep one active");
	sleep_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.gen_cfg_one[pgcfg_pkg::B_SLEEP_TWO_MASK] |=> !sleep_two_active)
		else $error("masked sleep two active");
	tsd_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.gen_cfg_one[pgcfg_pkg::B_TSD_ORD] |=> ordered_shutdown_threshold_c == pgcfg_pkg::TSD_ORD_HI)
		else $error("shutdown threshold wrong");
	sync_freq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.sync_freq[1:0] == 2'h3 |=> sync_expected_khz == pgcfg_pkg::SYNC_KHZ_3)
		else $error("sync frequency decode wrong");
	sync_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.sync_freq[1:0] == 2'h0 |=> sync_expected_khz == pgcfg_pkg::SYNC_KHZ_0)
		else $error("sync code zero decode wrong");

	// Register writes reaching the decoded fields, and the load winning over a write
	sequence gen_wr_s;
		reg_wr && !nvm_load && reg_addr == pgcfg_pkg::OFS_GEN_CFG_ONE;
	endsequence
	sequence sync_wr_s;
		reg_wr && !nvm_load && reg_addr == pgcfg_pkg::OFS_SYNC_FREQ;
	endsequence
	nvm_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		nvm_load && reg_wr && reg_addr == pgcfg_pkg::OFS_PG_SEL_FOUR |=>
		st.pg_sel_four == $past(nvm_pg_sel_four))
		else $error("load lost to a register write");
	i2c_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		gen_wr_s |=> {second_i2c_high_speed_force, first_i2c_high_speed_force} ==
		$past(reg_wdata[4:3]))
		else $error("i2c speed bits not written");
	sync_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sync_wr_s |=> sync_input_frequency_field == $past(reg_wdata[1:0]))
		else $error("sync field not written");

	// Thermal thresholds at their other settings
	tsd_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!st.gen_cfg_one[pgcfg_pkg::B_TSD_ORD] |=>
		ordered_shutdown_threshold_c == pgcfg_pkg::TSD_ORD_LO)
		else $error("low shutdown threshold wrong");
	twarn_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.gen_cfg_one[pgcfg_pkg::B_TWARN_LVL] |=>
		thermal_warning_threshold_c == pgcfg_pkg::TWARN_HI)
		else $error("high warning threshold wrong");
	twarn_lo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!st.gen_cfg_one[pgcfg_pkg::B_TWARN_LVL] |=>
		thermal_warning_threshold_c == pgcfg_pkg::TWARN_LO)
		else $error("low warning threshold wrong");

	// Drive pin follows its control bit when not forced
	drv_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.drv_ctrl[pgcfg_pkg::B_DRV_CTRL] && !drive_output_force_low_bit |=> drive_output_pin)
		else $error("drive pin not following");

	// Unmasked sleep request and enabled current-limit paths
	sleep_open_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!st.gen_cfg_one[pgcfg_pkg::B_SLEEP_ONE_MASK] && !sleep_one_register_twin |=>
		sleep_one_active)
		else $error("unmasked sleep one lost");
	current_limit_event_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st.gen_cfg_one[pgcfg_pkg::B_CURRENT_LIMIT_EVENT_TRIG] |=>
		current_limit_trigger == $past(current_limit_event))
		else $error("current limit not passed");

	// Overvoltage counts only in window mode
	window_ov_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		window_mode && st.pg_sel_four[pgcfg_pkg::B_PG_MON_ONE] && !mon_one_ov_ok |-> !all_valid)
		else $error("window overvoltage ignored");
	mon_uv_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!window_mode && st.pg_sel_four[pgcfg_pkg::B_PG_MON_ONE] |-> mon_one_ok == mon_one_uv_ok)
		else $error("undervoltage only check wrong");
endmodule // pgcfg_top
`default_nettype wire

// >>> power_good_and_misc_config_test.sv
/*
 Self-checking bench for the configuration slice: reset register reads,
 then table of power-good cases, sync, config, drive, load and second reset tests.
 Assumes the host model drives the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module power_good_and_misc_config_test;
	typedef struct packed {logic [7:0] sel; logic [7:0] bsel; logic [3:0] flt; logic pg;} pgcfg_row_s;
	logic sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid, nvm_load, rok;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdat, misc_control, v;
	logic [7:0] nvm_pg_sel_four, nvm_sync_freq, nvm_gen_cfg_one, pg_regulator_source_sel;
	logic [3:0] buck_uv_ok, buck_ov_ok, buck_current_limit_event_ok, current_limit_event, current_limit_trigger;
	logic mon_one_uv_ok, mon_one_ov_ok, mon_two_uv_ok, mon_two_ov_ok, analog_uv_ok, analog_ov_ok;
	logic thermal_warn, soc_reset_output_pin, general_reset_output_pin, drive_output_force_low_bit;
	logic sleep_one_pins, sleep_one_register_twin, sleep_two_pins, sleep_two_register_twin;
	logic power_good_output, drive_output_pin, sleep_one_to_seq, sleep_one_active;
	logic sleep_two_to_seq, sleep_two_active, first_i2c_high_speed_force, second_i2c_high_speed_force;
	logic [1:0] sync_input_frequency_field;
	logic [13:0] sync_expected_khz;
	logic [7:0] ordered_shutdown_threshold_c, thermal_warning_threshold_c;
	int errors = 0;
	int samples_checked = 0;
	// Select, buck select, fault code, expected power-good
	pgcfg_row_s rows [23] = '{'{8'h00, 8'h00, 4'h0, 1'b1}, '{8'h40, 8'h00, 4'h0, 1'b0},
		'{8'h02, 8'h00, 4'h1, 1'b0}, '{8'h00, 8'h00, 4'h1, 1'b1}, '{8'h02, 8'h00, 4'h2, 1'b1},
		'{8'h82, 8'h00, 4'h2, 1'b0}, '{8'h04, 8'h00, 4'h3, 1'b0}, '{8'h81, 8'h00, 4'h4, 1'b0},
		'{8'h01, 8'h00, 4'h4, 1'b1}, '{8'h08, 8'h00, 4'h5, 1'b0}, '{8'h00, 8'h00, 4'h5, 1'b1},
		'{8'h20, 8'h00, 4'h6, 1'b0}, '{8'h00, 8'h00, 4'h6, 1'b1}, '{8'h10, 8'h00, 4'h7, 1'b0},
		'{8'h00, 8'h00, 4'h7, 1'b1}, '{8'h00, 8'h01, 4'h8, 1'b0}, '{8'h00, 8'h00, 4'h8, 1'b1},
		'{8'h00, 8'h01, 4'h9, 1'b1}, '{8'h00, 8'h02, 4'h9, 1'b0}, '{8'h00, 8'h03, 4'h9, 1'b0},
		'{8'h48, 8'h00, 4'h5, 1'b1}, '{8'h80, 8'h01, 4'ha, 1'b0}, '{8'h00, 8'h01, 4'ha, 1'b1}};
	logic [13:0] khz [4] = '{14'h44c, 14'h898, 14'h1130, 14'h2260};
	// Clock
	always #2 sys_clk = ~sys_clk;
	pgcfg_top #(.NUM_BUCK(4)) dut_u (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .nvm_load, .nvm_pg_sel_four, .nvm_sync_freq, .nvm_gen_cfg_one,
		.pg_regulator_source_sel, .buck_uv_ok, .buck_ov_ok, .buck_current_limit_event_ok, .mon_one_uv_ok,
		.mon_one_ov_ok, .mon_two_uv_ok, .mon_two_ov_ok, .analog_uv_ok, .analog_ov_ok, .thermal_warn,
		.soc_reset_output_pin, .general_reset_output_pin, .drive_output_force_low_bit,
		.sleep_one_pins, .sleep_one_register_twin, .sleep_two_pins, .sleep_two_register_twin,
		.current_limit_event, .power_good_output, .drive_output_pin, .sync_input_frequency_field,
		.sync_expected_khz, .sleep_one_to_seq, .sleep_one_active, .sleep_two_to_seq,
		.sleep_two_active, .current_limit_trigger, .first_i2c_high_speed_force,
		.second_i2c_high_speed_force, .ordered_shutdown_threshold_c, .thermal_warning_threshold_c,
		.misc_control);
	pgcfg_host host_u (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
	// Verdict and end of run
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Compare one value
	task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Read a register and compare; a lost answer ends the run
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host_u.rd(a, rdat, rok);
		if (rok !== 1'b1) begin
			errors++;
			results();
		end
		check($sformatf("reg %h", a), {6'h00, rdat}, {6'h00, exp});
	endtask
	// Let registered outputs follow
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	// Apply one fault code and buck select to the power-good source inputs
	task automatic set_flt(input logic [3:0] f, input logic [7:0] b);
		@(posedge sys_clk);
		pg_regulator_source_sel <= b;
		mon_one_uv_ok <= (f != 4'h1);
		mon_one_ov_ok <= (f != 4'h2);
		mon_two_uv_ok <= (f != 4'h3);
		analog_ov_ok <= (f != 4'h4);
		thermal_warn <= (f == 4'h5);
		soc_reset_output_pin <= (f != 4'h6);
		general_reset_output_pin <= (f != 4'h7);
		buck_uv_ok <= {3'h7, f != 4'h8};
		buck_ov_ok <= {3'h7, f != 4'ha};
		buck_current_limit_event_ok <= {3'h7, f != 4'h9};
	endtask
	// Main sequence
	initial begin
		{sys_clk, rst_n, nvm_load, thermal_warn, drive_output_force_low_bit} = 5'h00;
		{nvm_pg_sel_four, nvm_sync_freq, nvm_gen_cfg_one, pg_regulator_source_sel} = 32'h0;
		{mon_one_uv_ok, mon_one_ov_ok, mon_two_uv_ok, mon_two_ov_ok, analog_uv_ok} = 5'h1f;
		{analog_ov_ok, soc_reset_output_pin, general_reset_output_pin} = 3'h7;
		{buck_uv_ok, buck_ov_ok, buck_current_limit_event_ok, current_limit_event} = 16'hfffa;
		{sleep_one_pins, sleep_one_register_twin, sleep_two_pins, sleep_two_register_twin} = 4'h0;
		repeat (4) @(posedge sys_clk);
		check("khz", sync_expected_khz, khz[0]);
		rst_n <= 1'b1;
		rchk(pgcfg_pkg::OFS_PG_SEL_FOUR, pgcfg_pkg::RST_PG_SEL_FOUR);
		rchk(pgcfg_pkg::OFS_SYNC_FREQ, pgcfg_pkg::RST_SYNC_FREQ);
		rchk(pgcfg_pkg::OFS_GEN_CFG_ONE, pgcfg_pkg::RST_GEN_CFG_ONE);
		rchk(pgcfg_pkg::OFS_DRV_CTRL, pgcfg_pkg::RST_DRV_CTRL);
		rchk(pgcfg_pkg::OFS_MISC_CTRL, pgcfg_pkg::RST_MISC_CTRL);
		host_u.wr(8'h7e, 8'hff);
		rchk(8'h7e, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			set_flt(rows[i].flt, rows[i].bsel);
			host_u.wr(pgcfg_pkg::OFS_PG_SEL_FOUR, rows[i].sel);
			settle();
			check($sformatf("pg row %0d", i), power_good_output, rows[i].pg);
		end
		$display("test power_good done");
		for (int c = 0; c < 4; c++) begin
			host_u.wr(pgcfg_pkg::OFS_SYNC_FREQ, 8'hfc | c[7:0]);
			rchk(pgcfg_pkg::OFS_SYNC_FREQ, c[7:0]);
			check("freq", sync_input_frequency_field, c[1:0]);
			check("khz", sync_expected_khz, khz[c]);
		end
		$display("test sync done");
		foreach (rows[i]) if (i < 4) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'h7f : 8'hff;
			host_u.wr(pgcfg_pkg::OFS_GEN_CFG_ONE, v);
			settle();
			rchk(pgcfg_pkg::OFS_GEN_CFG_ONE, v);
			check("seq two", {sleep_two_to_seq, sleep_two_active}, {2{~v[7]}});
			check("seq one", {sleep_one_to_seq, sleep_one_active}, {2{~v[6]}});
			check("trig", current_limit_trigger, v[5] ? 4'ha : 4'h0);
			check("i2c", {second_i2c_high_speed_force, first_i2c_high_speed_force}, v[4:3]);
			check("tsd", ordered_shutdown_threshold_c, v[1] ? 8'h91 : 8'h8c);
			check("twarn", thermal_warning_threshold_c, v[0] ? 8'h8c : 8'h82);
		end
		host_u.wr(pgcfg_pkg::OFS_GEN_CFG_ONE, 8'h00);
		{sleep_one_pins, sleep_one_register_twin, sleep_two_pins, sleep_two_register_twin} <= 4'hb;
		settle();
		check("sleep", {sleep_one_active, sleep_two_active}, 2'b10);
		$display("test config done");
		host_u.wr(pgcfg_pkg::OFS_DRV_CTRL, 8'hff);
		rchk(pgcfg_pkg::OFS_DRV_CTRL, 8'h01);
		settle();
		check("drv", drive_output_pin, 1'b1);
		@(posedge sys_clk);
		drive_output_force_low_bit <= 1'b1;
		settle();
		check("drv low", drive_output_pin, 1'b0);
		@(posedge sys_clk);
		drive_output_force_low_bit <= 1'b0;
		host_u.wr(pgcfg_pkg::OFS_DRV_CTRL, 8'h00);
		settle();
		check("drv off", drive_output_pin, 1'b0);
		host_u.wr(pgcfg_pkg::OFS_MISC_CTRL, 8'ha5);
		rchk(pgcfg_pkg::OFS_MISC_CTRL, 8'ha5);
		check("misc", misc_control, 8'ha5);
		$display("test drive done");
		@(posedge sys_clk);
		{nvm_pg_sel_four, nvm_sync_freq, nvm_gen_cfg_one} <= 24'h3c021d;
		fork
			host_u.wr(pgcfg_pkg::OFS_PG_SEL_FOUR, 8'h55);
			begin
				@(posedge sys_clk);
				nvm_load <= 1'b1;
				@(posedge sys_clk);
				nvm_load <= 1'b0;
			end
		join
		rchk(pgcfg_pkg::OFS_PG_SEL_FOUR, 8'h3c);
		rchk(pgcfg_pkg::OFS_SYNC_FREQ, 8'h02);
		rchk(pgcfg_pkg::OFS_GEN_CFG_ONE, 8'h1d);
		$display("test load done");
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		rchk(pgcfg_pkg::OFS_GEN_CFG_ONE, pgcfg_pkg::RST_GEN_CFG_ONE);
		rchk(pgcfg_pkg::OFS_MISC_CTRL, pgcfg_pkg::RST_MISC_CTRL);
		$display("test second reset done");
		results();
	end
endmodule // power_good_and_misc_config_test
`default_nettype wire
